// file: contact_threshold_evaluator.sv
// Contact threshold evaluator: level input and binary input contact channels,
// supply monitoring and an Avalon-MM register slave.
// Assumes digit values and sample_valid_in come from front-end logic on core_clk_in.
`timescale 1ns/1ns
`include "cte_defines.svh"

module contact_threshold_evaluator #(
   parameter int LEVEL_CH = 8,
   parameter int GROUPS   = 3,
   parameter int GROUP_CH = 8
) (
   input  wire logic                               core_clk_in,
   input  wire logic                               reset_in,
   input  wire logic [2:0]                         avs_address_in,
   input  wire logic                               avs_read_in,
   input  wire logic                               avs_write_in,
   input  wire logic [31:0]                        avs_writedata_in,
   input  wire logic [3:0]                         avs_byteenable_in,
   output logic [31:0]                             avs_readdata_out,
   output logic                                    avs_waitrequest_out,
   input  wire logic                               sample_valid_in,
   input  wire logic [LEVEL_CH*12-1:0]             level_value_in,
   input  wire logic [11:0]                        level_supply_in,
   input  wire logic [GROUPS*GROUP_CH*12-1:0]      bin_value_in,
   output logic [LEVEL_CH-1:0]                     level_state_out,
   output logic [LEVEL_CH-1:0]                     level_fault_out,
   output logic [GROUPS*(GROUP_CH-1)-1:0]          bin_state_out,
   output logic [GROUPS*(GROUP_CH-1)-1:0]          bin_fault_out,
   output logic                                    level_supply_ok_out
);

   localparam int BIN_CONTACTS = GROUPS * (GROUP_CH - 1);

   // ------------------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------------------
   // Maps a contact position within a group to its raw channel, skipping the
   // supply read-back slot.
   function automatic int raw_index(input int grp, input int pos);
      int slot;
      slot = (pos >= `BIN_SUPPLY_SLOT) ? pos + 1 : pos;
      return grp * GROUP_CH + slot;
   endfunction

   // Pads a narrow status vector into a bus word.
   function automatic logic [31:0] widen(input logic [BIN_CONTACTS-1:0] bits);
      logic [31:0] word;
      word = 32'h0000_0000;
      word[BIN_CONTACTS-1:0] = bits;
      return word;
   endfunction

   // ------------------------------------------------------------------------
   // Control and evaluation pulse
   // ------------------------------------------------------------------------
   logic                  eval_enable_ff;
   logic                  eval;
   logic [15:0]           eval_count_ff;
   logic                  supply_in_range;
   logic                  supply_ok_ff;
   logic                  supply_bad;
   cte_pkg::limits_t      level_limits;
   cte_pkg::limits_t      bin_limits [GROUPS];
   logic [11:0]           group_short [GROUPS];
   logic [LEVEL_CH*12-1:0] level_clamped;

   // A sample is evaluated only while software has evaluation enabled.
   assign eval = sample_valid_in & eval_enable_ff;

   // Counts evaluation passes so software can see the block is alive.
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         eval_count_ff <= 16'h0000;
      end else if (eval) begin
         eval_count_ff <= eval_count_ff + 16'h0001;
      end
   end

   // ------------------------------------------------------------------------
   // Level input supply monitor
   // ------------------------------------------------------------------------
   // The tied level supplies arrive here as one analog read-back value.
   supply_window level_supply_chk (
      .value_in      (level_supply_in),
      .low_in        (`SUPPLY_LOW_LIMIT),
      .high_in       (`SUPPLY_HIGH_LIMIT),
      .margin_in     (12'h000),
      .in_range_out  (supply_in_range),
      .short_lim_out ()
   );

   // The faulty marking follows the live range check, so it clears on the
   // first pass back inside the window.
   assign supply_bad = ~supply_in_range;

   // Registered copy of the supply state for the status output.
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         supply_ok_ff <= 1'b0;
      end else if (eval) begin
         supply_ok_ff <= supply_in_range;
      end
   end

   // ------------------------------------------------------------------------
   // Level input contact channels
   // ------------------------------------------------------------------------
   // Fixed threshold set on the full scale setting.
   always_comb begin
      level_limits.on_lim    = `LEVEL_ON_LIMIT;
      level_limits.off_lim   = `LEVEL_OFF_LIMIT;
      level_limits.open_lim  = `LEVEL_OPEN_LIMIT;
      level_limits.short_lim = `LEVEL_SHORT_LIMIT;
   end

   // Each level channel is clamped to full scale and evaluated inclusively.
   for (genvar i = 0; i < LEVEL_CH; i++) begin : g_level
      assign level_clamped[i*12 +: 12] =
         (level_value_in[i*12 +: 12] > `FULL_SCALE_SETTING) ?
         `FULL_SCALE_SETTING : level_value_in[i*12 +: 12];

      contact_channel #(
         .STRICT     (1'b0),
         .FORCE_ZERO (1'b0)
      ) level_ch (
         .core_clk_in    (core_clk_in),
         .reset_in       (reset_in),
         .eval_in        (eval),
         .value_in       (level_clamped[i*12 +: 12]),
         .limits_in      (level_limits),
         .extra_fault_in (supply_bad),
         .state_out      (level_state_out[i]),
         .fault_out      (level_fault_out[i])
      );
   end

   // ------------------------------------------------------------------------
   // Binary input groups
   // ------------------------------------------------------------------------
   // Each group derives its own short limit from its own supply slot.
   for (genvar g = 0; g < GROUPS; g++) begin : g_group
      supply_window group_chk (
         .value_in      (bin_value_in[(g*GROUP_CH + `BIN_SUPPLY_SLOT)*12 +: 12]),
         .low_in        (12'h000),
         .high_in       (12'hFFF),
         .margin_in     (`BIN_SHORT_MARGIN),
         .in_range_out  (),
         .short_lim_out (group_short[g])
      );

      always_comb begin
         bin_limits[g].on_lim    = `BIN_ON_LIMIT;
         bin_limits[g].off_lim   = `BIN_OFF_LIMIT;
         bin_limits[g].open_lim  = `BIN_OPEN_LIMIT;
         bin_limits[g].short_lim = group_short[g];
      end

      // The remaining contacts of the group switch on strict limits and
      // read zero while faulty.
      for (genvar k = 0; k < GROUP_CH - 1; k++) begin : g_contact
         contact_channel #(
            .STRICT     (1'b1),
            .FORCE_ZERO (1'b1)
         ) bin_ch (
            .core_clk_in    (core_clk_in),
            .reset_in       (reset_in),
            .eval_in        (eval),
            .value_in       (bin_value_in[raw_index(g, k)*12 +: 12]),
            .limits_in      (bin_limits[g]),
            .extra_fault_in (1'b0),
            .state_out      (bin_state_out[g*(GROUP_CH-1) + k]),
            .fault_out      (bin_fault_out[g*(GROUP_CH-1) + k])
         );
      end
   end

   assign level_supply_ok_out = supply_ok_ff;

   // ------------------------------------------------------------------------
   // Avalon-MM slave
   // ------------------------------------------------------------------------
   cte_pkg::bus_state_t bus_state_ff;
   logic                waitrequest_ff;
   logic [31:0]         readdata_ff;
   logic [31:0]         nxt_readdata;

   // Read multiplexer; unmapped words read as zero.
   always_comb begin
      case (avs_address_in)
         `REG_CTRL: begin
            nxt_readdata = {31'h0000_0000, eval_enable_ff};
         end
         `REG_STATUS: begin
            nxt_readdata = {eval_count_ff, 15'h0000, supply_ok_ff};
         end
         `REG_LEVEL: begin
            nxt_readdata = 32'h0000_0000;
            nxt_readdata[LEVEL_CH-1:0] = level_state_out;
            nxt_readdata[8 +: LEVEL_CH] = level_fault_out;
         end
         `REG_BIN_STATE: begin
            nxt_readdata = widen(bin_state_out);
         end
         `REG_BIN_FAULT: begin
            nxt_readdata = widen(bin_fault_out);
         end
         `REG_LEVEL_SUPPLY: begin
            nxt_readdata = {20'h0_0000, level_supply_in};
         end
         default: begin
            nxt_readdata = 32'h0000_0000;
         end
      endcase
   end

   // Every request waits one cycle, then waitrequest drops for one cycle.
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         bus_state_ff   <= cte_pkg::BUS_IDLE;
         waitrequest_ff <= 1'b1;
         readdata_ff    <= 32'h0000_0000;
      end else begin
         case (bus_state_ff)
            cte_pkg::BUS_IDLE: begin
               if (avs_read_in || avs_write_in) begin
                  bus_state_ff   <= cte_pkg::BUS_ANSWER;
                  waitrequest_ff <= 1'b0;
                  readdata_ff    <= avs_read_in ? nxt_readdata : 32'h0000_0000;
               end
            end
            cte_pkg::BUS_ANSWER: begin
               bus_state_ff   <= cte_pkg::BUS_IDLE;
               waitrequest_ff <= 1'b1;
            end
            default: begin
               bus_state_ff   <= cte_pkg::BUS_IDLE;
               waitrequest_ff <= 1'b1;
            end
         endcase
      end
   end

   // The control word is written at the edge where waitrequest is seen low.
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         eval_enable_ff <= `CTRL_RESET;
      end else if (avs_write_in && !waitrequest_ff && avs_address_in == `REG_CTRL
                   && avs_byteenable_in[0]) begin
         eval_enable_ff <= avs_writedata_in[`CTRL_EVAL_EN_BIT];
      end
   end

   assign avs_readdata_out    = readdata_ff;
   assign avs_waitrequest_out = waitrequest_ff;

   // ------------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------------
   logic [11:0] ai0;
   logic [11:0] bin0;
   logic [11:0] sup0;
   assign ai0  = level_clamped[11:0];
   assign bin0 = bin_value_in[11:0];
   assign sup0 = bin_value_in[`BIN_SUPPLY_SLOT*12 +: 12];

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (reset_in);

   a_ai_full_scale: assert property (
      ai0 <= `FULL_SCALE_SETTING) else $error("Level value exceeds full scale.");
   a_ai_switch_on: assert property (
      eval && ai0 >= `LEVEL_ON_LIMIT |=> level_state_out[0])
      else $error("Level contact did not switch on.");
   a_ai_switch_off: assert property (
      eval && ai0 <= `LEVEL_OFF_LIMIT |=> !level_state_out[0])
      else $error("Level contact did not switch off.");
   a_ai_line_fault: assert property (
      eval && (ai0 <= `LEVEL_OPEN_LIMIT || ai0 >= `LEVEL_SHORT_LIMIT) |=> level_fault_out[0])
      else $error("Level line fault not flagged.");
   a_supply_range: assert property (
      eval |=> level_supply_ok_out == ($past(level_supply_in) >= `SUPPLY_LOW_LIMIT
                                        && $past(level_supply_in) <= `SUPPLY_HIGH_LIMIT))
      else $error("Supply range status wrong.");
   a_supply_fault: assert property (
      eval && !supply_in_range |=> &level_fault_out)
      else $error("Supply fault did not mark level channels.");
   a_supply_resume: assert property (
      eval && supply_in_range && ai0 > `LEVEL_OPEN_LIMIT && ai0 < `LEVEL_SHORT_LIMIT
      |=> !level_fault_out[0]) else $error("Level channel did not resume.");
   a_bin_switch: assert property (
      eval && bin0 > `BIN_ON_LIMIT && bin0 <= 12'(sup0 - `BIN_SHORT_MARGIN)
      && sup0 > `BIN_SHORT_MARGIN |=> bin_state_out[0])
      else $error("Binary contact did not switch on.");
   a_bin_open: assert property (
      eval && bin0 < `BIN_OPEN_LIMIT |=> !bin_state_out[0] && bin_fault_out[0])
      else $error("Binary open wire not forced to zero.");
   a_bin_short: assert property (
      eval && sup0 > `BIN_SHORT_MARGIN && bin0 > 12'(sup0 - `BIN_SHORT_MARGIN)
      |=> !bin_state_out[0] && bin_fault_out[0])
      else $error("Binary short not forced to zero.");
   a_hold_between: assert property (
      eval && ai0 > `LEVEL_OFF_LIMIT && ai0 < `LEVEL_ON_LIMIT |=> $stable(level_state_out[0]))
      else $error("Level contact moved inside hysteresis band.");
   a_no_eval_hold: assert property (
      !eval |=> $stable(level_state_out) && $stable(bin_state_out))
      else $error("Channel state changed without evaluation.");
   a_bus_answer: assert property (
      (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out ##1
      avs_waitrequest_out) else $error("Bus answer timing wrong.");

endmodule

// file: cte_defines.svh
// Constants for the contact threshold evaluator: register map, field positions,
// reset values and digit thresholds.
// Assumes a 12-bit digit scale from the input front end and word-indexed Avalon addresses.
`ifndef CTE_DEFINES_SVH
`define CTE_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (word addresses on the Avalon-MM slave)
// ----------------------------------------------------------------------------
`define REG_CTRL          3'h0
`define REG_STATUS        3'h1
`define REG_LEVEL         3'h2
`define REG_BIN_STATE     3'h3
`define REG_BIN_FAULT     3'h4
`define REG_LEVEL_SUPPLY  3'h5

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define CTRL_EVAL_EN_BIT  0
`define CTRL_RESET        1'h1
`define STATUS_OK_BIT     0
`define STATUS_CNT_LSB    16

// ----------------------------------------------------------------------------
// Level input channel thresholds on the full scale setting
// ----------------------------------------------------------------------------
`define FULL_SCALE_SETTING  12'h7D0
`define LEVEL_ON_LIMIT      12'h4B0
`define LEVEL_OFF_LIMIT     12'h258
`define LEVEL_OPEN_LIMIT    12'h064
`define LEVEL_SHORT_LIMIT   12'h690

// ----------------------------------------------------------------------------
// Supply monitor range for the level input supply read-back
// ----------------------------------------------------------------------------
`define SUPPLY_LOW_LIMIT    12'hA28
`define SUPPLY_HIGH_LIMIT   12'hAF0

// ----------------------------------------------------------------------------
// Binary input channel thresholds
// ----------------------------------------------------------------------------
`define BIN_ON_LIMIT        12'h4B0
`define BIN_OFF_LIMIT       12'h3E8
`define BIN_OPEN_LIMIT      12'h0C8
`define BIN_SHORT_MARGIN    12'h06E
`define BIN_SUPPLY_SLOT     7

`endif

// file: cte_pkg.sv
// Types shared by the contact threshold evaluator modules.
// Assumes 12-bit digit values throughout.
package cte_pkg;

   // Threshold set handed to one contact channel.
   typedef struct packed {
      logic [11:0] on_lim;
      logic [11:0] off_lim;
      logic [11:0] open_lim;
      logic [11:0] short_lim;
   } limits_t;

   // Avalon slave answer sequencing.
   typedef enum logic [0:0] {
      BUS_IDLE,
      BUS_ANSWER
   } bus_state_t;

endpackage

// file: supply_window.sv
// Range check of a supply read-back and derivation of a short limit from it.
// Assumes inputs on the same clock; purely combinational.
`timescale 1ns/1ns
module supply_window (
   input  wire logic [11:0] value_in,
   input  wire logic [11:0] low_in,
   input  wire logic [11:0] high_in,
   input  wire logic [11:0] margin_in,
   output logic             in_range_out,
   output logic [11:0]      short_lim_out
);

   // ------------------------------------------------------------------------
   // Range and limit
   // ------------------------------------------------------------------------
   // Outside means strictly below the low or strictly above the high limit.
   // The limit saturates at zero so a collapsed supply never wraps upward.
   always_comb begin
      in_range_out  = (value_in >= low_in) && (value_in <= high_in);
      short_lim_out = (value_in > margin_in) ? 12'(value_in - margin_in) : 12'h000;
   end

endmodule

// file: contact_channel.sv
// One contact channel: hysteresis on a digit value plus open and short detection.
// Assumes eval_in is a one-cycle pulse on core_clk_in marking a new sample.
`timescale 1ns/1ns
module contact_channel #(
   parameter bit STRICT     = 1'b0,
   parameter bit FORCE_ZERO = 1'b0
) (
   input  wire logic            core_clk_in,
   input  wire logic            reset_in,
   input  wire logic            eval_in,
   input  wire logic [11:0]     value_in,
   input  wire cte_pkg::limits_t limits_in,
   input  wire logic            extra_fault_in,
   output logic                 state_out,
   output logic                 fault_out
);

   logic above_on;
   logic below_off;
   logic open_hit;
   logic short_hit;
   logic fault_now;
   logic nxt_hyst;
   logic hyst_ff;
   logic state_ff;
   logic fault_ff;

   // ------------------------------------------------------------------------
   // Threshold compares
   // ------------------------------------------------------------------------
   // Strict channels switch beyond a limit, inclusive channels on reaching it.
   always_comb begin
      if (STRICT) begin
         above_on  = value_in > limits_in.on_lim;
         below_off = value_in < limits_in.off_lim;
         open_hit  = value_in < limits_in.open_lim;
         short_hit = value_in > limits_in.short_lim;
      end else begin
         above_on  = value_in >= limits_in.on_lim;
         below_off = value_in <= limits_in.off_lim;
         open_hit  = value_in <= limits_in.open_lim;
         short_hit = value_in >= limits_in.short_lim;
      end
      nxt_hyst  = above_on ? 1'b1 : (below_off ? 1'b0 : hyst_ff);
      fault_now = open_hit | short_hit | extra_fault_in;
   end

   // Hysteresis memory moves only on an evaluation pulse.
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         hyst_ff <= 1'b0;
      end else if (eval_in) begin
         hyst_ff <= nxt_hyst;
      end
   end

   // A fault masks the state on channels that force zero.
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_ff <= 1'b0;
         fault_ff <= 1'b0;
      end else if (eval_in) begin
         state_ff <= (FORCE_ZERO && fault_now) ? 1'b0 : nxt_hyst;
         fault_ff <= fault_now;
      end
   end

   assign state_out = state_ff;
   assign fault_out = fault_ff;

endmodule

// file: contact_field.sv
// Model of the contacts and supplies wired to the evaluator inputs.
// Assumes the bench sets values through its tasks and asks for one sample set at a time.
`timescale 1ns/1ns
module contact_field (
   input  wire logic   core_clk_in,
   output logic        sample_valid_out,
   output logic [95:0] level_value_out,
   output logic [11:0] level_supply_out,
   output logic [287:0] bin_value_out
);
   // Idle contacts sit between thresholds, and every supply is healthy.
   initial begin
      sample_valid_out = 1'b0;
      level_value_out  = {8{12'h3E8}};
      level_supply_out = 12'hA8C;
      bin_value_out    = {3{12'h7D0, {7{12'h44C}}}};
   end

   // Changes one channel value, or the tied level supply read-back, after an edge.
   task automatic set_val(input int kind, input int ch, input logic [11:0] v);
      @(posedge core_clk_in);
      case (kind)
         0: level_value_out[ch*12+:12] <= v;
         1: bin_value_out[ch*12+:12] <= v;
         default: level_supply_out <= v;
      endcase
   endtask

   // Presents the current sample set for exactly one cycle.
   task automatic sample();
      @(posedge core_clk_in);
      sample_valid_out <= 1'b1;
      @(posedge core_clk_in);
      sample_valid_out <= 1'b0;
   endtask
endmodule

// file: contact_threshold_evaluator_tb.sv
// Self-checking bench for the contact threshold evaluator.
// Assumes the contact_field model drives all sample inputs; the bench drives the register bus.
`timescale 1ns/1ns
`include "cte_defines.svh"
module contact_threshold_evaluator_tb;
   logic         core_clk_in;
   logic         reset_in;
   logic [2:0]   avs_address_in;
   logic         avs_read_in;
   logic         avs_write_in;
   logic [31:0]  avs_writedata_in;
   logic [31:0]  avs_readdata_out;
   logic         avs_waitrequest_out;
   logic         sample_valid_in;
   logic [95:0]  level_value_in;
   logic [11:0]  level_supply_in;
   logic [287:0] bin_value_in;
   logic [7:0]   level_state_out;
   logic [7:0]   level_fault_out;
   logic [20:0]  bin_state_out;
   logic [20:0]  bin_fault_out;
   logic         level_supply_ok_out;
   logic [31:0]  rd;
   int           err_total = 0;
   int           n_tests = 0;

   contact_field field (.core_clk_in(core_clk_in), .sample_valid_out(sample_valid_in),
      .level_value_out(level_value_in), .level_supply_out(level_supply_in),
      .bin_value_out(bin_value_in));

   contact_threshold_evaluator uut (.core_clk_in(core_clk_in), .reset_in(reset_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .sample_valid_in(sample_valid_in),
      .level_value_in(level_value_in), .level_supply_in(level_supply_in),
      .bin_value_in(bin_value_in), .level_state_out(level_state_out),
      .level_fault_out(level_fault_out), .bin_state_out(bin_state_out),
      .bin_fault_out(bin_fault_out), .level_supply_ok_out(level_supply_ok_out));

   // Free-running 100 MHz clock.
   initial begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end

   // Prints the verdict and ends the run.
   task automatic finish_test();
      if (err_total == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Compares one result against its expected value.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One Avalon transfer, held until waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd);
      int i;
      @(posedge core_clk_in);
      avs_address_in <= a;
      avs_writedata_in <= wd;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      for (i = 0; i < 50; i++) begin
         @(posedge core_clk_in);
         if (avs_waitrequest_out === 1'b0) break;
      end
      rd = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      if (i == 50) begin
         err_total++;
         finish_test();
      end
   endtask

   // Sets one value, presents a sample, and lets the result land.
   task automatic ev(input int kind, input int ch, input logic [11:0] v);
      field.set_val(kind, ch, v);
      field.sample();
      #1;
   endtask

   // Level channel thresholds, hysteresis hold and the full-scale clamp.
   task automatic level_case();
      int v[9] = '{1199, 1200, 601, 600, 100, 101, 1680, 4095, 1679};
      logic [1:0] e[9] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h2, 2'h0, 2'h3, 2'h3, 2'h1};
      for (int i = 0; i < 9; i++) begin
         ev(0, 0, v[i][11:0]);
         chk({level_fault_out[0], level_state_out[0]}, e[i]);
      end
   endtask

   // Level supply window marks all level channels faulty and then recovers.
   task automatic supply_case();
      int v[5] = '{2599, 2600, 2800, 2801, 2700};
      logic [8:0] e[5] = '{9'h0FF, 9'h100, 9'h100, 9'h0FF, 9'h100};
      for (int i = 0; i < 5; i++) begin
         ev(2, 0, v[i][11:0]);
         chk({level_supply_ok_out, level_fault_out}, e[i]);
      end
   endtask

   // Binary channels in each group use their own supply for the short limit.
   task automatic bin_case();
      int s;
      int v[8];
      logic [1:0] e[8] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h2, 2'h0, 2'h1, 2'h2};
      for (int g = 0; g < 3; g++) begin
         s = 1500 + g * 200;
         ev(1, g * 8 + 7, s[11:0]);
         v = '{1200, 1201, 1000, 999, 199, 200, s - 110, s - 109};
         for (int i = 0; i < 8; i++) begin
            ev(1, g * 8 + 3, v[i][11:0]);
            chk({bin_fault_out[g*7+3], bin_state_out[g*7+3]}, e[i]);
         end
      end
   endtask

   // Evaluation enable gates sampling; registers and unmapped reads.
   task automatic reg_case();
      bus(1'b0, `REG_CTRL, 32'h0);
      chk(rd, 32'h1);
      bus(1'b0, 3'h6, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, `REG_CTRL, 32'h0);
      ev(0, 0, 12'h5DC);
      chk({31'h0, level_state_out[0]}, 32'h0);
      bus(1'b1, `REG_CTRL, 32'h1);
      ev(0, 0, 12'h5DC);
      chk({31'h0, level_state_out[0]}, 32'h1);
      ev(0, 0, 12'h1F4);
      chk({31'h0, level_state_out[0]}, 32'h0);
      bus(1'b0, `REG_STATUS, 32'h0);
      chk(rd, 32'h0002_0001);
      bus(1'b0, `REG_LEVEL, 32'h0);
      chk(rd, 32'h0);
   endtask

   // Reset, then the scenarios in turn.
   initial begin
      reset_in = 1'b1;
      avs_address_in = 3'h0;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_writedata_in = 32'h0;
      repeat (10) @(posedge core_clk_in);
      reset_in <= 1'b0;
      reg_case();
      level_case();
      supply_case();
      bin_case();
      finish_test();
   end
endmodule
